// file: verilog/adcsc_ctrl.sv
// sequencer control for a four channel successive conversion unit
//
// Behaviour
// - four channels, one converter, 8 or 9 bits
// - 8-bit variant: result bit n at bit n
// - 9-bit: high byte bits 8..1, low bit0 msb
// - one 8-bit control register holds start, end flag, pin config and channel
// - channel select routes exactly one input
// - pin config 100 or above: all pins analog
// - pin config zero: digital pins, converter off
// - start high then low launches conversion
// - start held high: reset, end flag one
// - start bit gates all conversion activity
// - end flag cleared when conversion finishes
// - completion sets request flag, raises interrupt
// - result readable after completion
// - converter clock divides by 2, 8, 32
// - conversion takes 64 or 76 periods
// - analog pins override direction, drop pull-high
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/100ps
module adcsc_ctrl #(
	parameter bit NINE_BIT = 1'b1
) (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// converter core
	input wire logic [8:0] core_result,
	output logic [3:0] core_channel_sel,
	output logic core_power,
	output logic core_reset,
	output logic core_clk_tick,
	output logic conv_busy,
	// port b pins
	output logic [3:0] pin_analog_en,
	// interrupt
	output logic conv_irq_req
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_HELD = 3'b010,
		ST_CONV = 3'b100
	} adcsc_state_t;

	typedef struct packed {
		logic start;
		logic conversion_pending_flag;
		logic [2:0] pin_cfg;
		logic [2:0] chan;
		logic [1:0] div_sel;
		logic irq_en;
		logic master_en;
		logic irq_flag;
		logic [8:0] result;
		adcsc_state_t state;
		logic [6:0] count;
		logic [31:0] prdata;
	} adcsc_regs_t;

	localparam logic [6:0] CONV_LAST = NINE_BIT ?
		7'(adcsc_pkg::CONV_PERIODS_9BIT - 1) : 7'(adcsc_pkg::CONV_PERIODS_8BIT - 1);

	adcsc_regs_t r;
	adcsc_regs_t next_r;
	logic tick;
	logic wr;
	logic rd_setup;
	logic hit;
	logic done;
	logic [7:0] ctl_byte;
	logic [31:0] rdata;

	// divider restarts with every conversion so the first period is whole
	adcsc_clkdiv u_div (
		.pclk(pclk),
		.presetn(presetn),
		.clr(r.state != ST_CONV),
		.div_sel(r.div_sel),
		.tick(tick)
	);

	assign wr = psel && penable && pwrite;
	assign rd_setup = psel && !penable;
	assign done = (r.state == ST_CONV) && tick && (r.count == CONV_LAST);

	assign ctl_byte = {r.start, r.conversion_pending_flag, r.pin_cfg, r.chan};

	// address decode and read mux; result registers depend on the variant
	always_comb begin
		hit = 1'b1;
		rdata = 32'h0000_0000;
		case (paddr)
			adcsc_pkg::ADDR_CONTROL: rdata[7:0] = ctl_byte;
			adcsc_pkg::ADDR_RESULT_BYTE: begin
				hit = !NINE_BIT;
				rdata[7:0] = r.result[7:0];
			end
			adcsc_pkg::ADDR_RESULT_LOW: begin
				hit = NINE_BIT;
				rdata[7:0] = {r.result[0], 7'h00};
			end
			adcsc_pkg::ADDR_RESULT_HIGH: begin
				hit = NINE_BIT;
				rdata[7:0] = r.result[8:1];
			end
			adcsc_pkg::ADDR_CLOCK_SRC: rdata[1:0] = r.div_sel;
			adcsc_pkg::ADDR_IRQ_ENABLE: rdata[1:0] = {r.master_en, r.irq_en};
			adcsc_pkg::ADDR_IRQ_STATUS: rdata[0] = r.irq_flag;
			default: hit = 1'b0;
		endcase
		if (!hit) begin
			rdata = 32'h0000_0000;
		end
	end

	always_comb begin
		next_r = r;
		if (rd_setup) begin
			next_r.prdata = rdata;
		end
		if (wr && hit) begin
			case (paddr)
				adcsc_pkg::ADDR_CONTROL: begin
					// the end flag is read-only, the write ignores it
					next_r.chan = pwdata[adcsc_pkg::CTL_CHAN_LSB +: 3];
					next_r.pin_cfg = pwdata[adcsc_pkg::CTL_PIN_LSB +: 3];
					next_r.start = pwdata[adcsc_pkg::CTL_START_BIT];
				end
				adcsc_pkg::ADDR_CLOCK_SRC: begin
					next_r.div_sel = pwdata[adcsc_pkg::DIV_SEL_LSB +: 2];
				end
				adcsc_pkg::ADDR_IRQ_ENABLE: begin
					next_r.irq_en = pwdata[adcsc_pkg::IRQ_EN_BIT];
					next_r.master_en = pwdata[adcsc_pkg::IRQ_MASTER_BIT];
				end
				adcsc_pkg::ADDR_IRQ_STATUS: begin
					if (pwdata[adcsc_pkg::IRQ_FLAG_BIT]) begin
						next_r.irq_flag = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		case (r.state)
			ST_IDLE: begin
				if (next_r.start) begin
					next_r.state = ST_HELD;
					next_r.conversion_pending_flag = 1'b1;
				end
			end
			ST_HELD: begin
				next_r.conversion_pending_flag = 1'b1;
				next_r.count = 7'h00;
				if (!next_r.start) begin
					// the falling edge of start is the launch event
					if (next_r.pin_cfg != 3'h0) begin
						next_r.state = ST_CONV;
					end else begin
						next_r.state = ST_IDLE;
					end
				end
			end
			ST_CONV: begin
				if (next_r.start) begin
					next_r.state = ST_HELD;
					next_r.conversion_pending_flag = 1'b1;
				end else if (next_r.pin_cfg == 3'h0) begin
					// powering down aborts; end flag stays high, result kept
					next_r.state = ST_IDLE;
				end else if (done) begin
					next_r.state = ST_IDLE;
					next_r.conversion_pending_flag = 1'b0;
					next_r.result = NINE_BIT ? core_result : {1'b0, core_result[7:0]};
					// set wins over a same-cycle software clear
					next_r.irq_flag = 1'b1;
				end else if (tick) begin
					next_r.count = r.count + 7'h01;
				end
			end
			default: begin
				next_r.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r.start <= 1'b0;
			r.conversion_pending_flag <= adcsc_pkg::RST_EOC;
			r.pin_cfg <= adcsc_pkg::RST_PIN_CFG;
			r.chan <= adcsc_pkg::RST_CHAN;
			r.div_sel <= adcsc_pkg::RST_DIV_SEL;
			r.irq_en <= 1'b0;
			r.master_en <= 1'b0;
			r.irq_flag <= 1'b0;
			r.result <= 9'h000;
			r.state <= ST_IDLE;
			r.count <= 7'h00;
			r.prdata <= 32'h0000_0000;
		end else begin
			r <= next_r;
		end
	end

	// the slave never stretches a transfer
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata = r.prdata;

	// the select msb is ignored, so a stray one still routes a single input
	always_comb begin
		core_channel_sel = 4'h0;
		core_channel_sel[r.chan[1:0]] = 1'b1;
	end

	// pin enables also tell the port to drop direction and pull-high
	always_comb begin
		case (r.pin_cfg)
			3'h0: pin_analog_en = 4'h0;
			3'h1: pin_analog_en = 4'h1;
			3'h2: pin_analog_en = 4'h3;
			3'h3: pin_analog_en = 4'h7;
			default: pin_analog_en = 4'hF;
		endcase
	end

	assign core_power = (r.pin_cfg != 3'h0);
	assign core_reset = r.start;
	assign conv_busy = (r.state == ST_CONV);
	assign core_clk_tick = tick && (r.state == ST_CONV);
	assign conv_irq_req = r.irq_flag && r.irq_en && r.master_en;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_start_fall;
		r.state == ST_HELD && !next_r.start && next_r.pin_cfg != 3'h0;
	endsequence

	sequence s_conv_end;
		done && !next_r.start && next_r.pin_cfg != 3'h0;
	endsequence

	a_launch_on_fall: assert property (s_start_fall |=> conv_busy && r.count == 7'h00)
		else $error("conversion not launched on start fall");

	a_held_eoc_high: assert property (r.start |-> r.conversion_pending_flag && r.state == ST_HELD && !conv_busy)
		else $error("start held but end flag low or busy");

	a_start_gates_conv: assert property (conv_busy |-> !r.start && core_power)
		else $error("conversion running while start high");

	a_end_clears_eoc: assert property (s_conv_end |=> !r.conversion_pending_flag && r.irq_flag && !conv_busy)
		else $error("end flag or request flag wrong after conversion");

	a_result_holds: assert property (conv_busy && !done |=> $stable(r.result))
		else $error("result changed during conversion");

	a_result_capture: assert property (s_conv_end |=>
		r.result[7:0] == $past(core_result[7:0]))
		else $error("result not captured at conversion end");

	a_end_at_length: assert property (done |-> r.count == CONV_LAST && core_clk_tick)
		else $error("conversion ended at wrong length");

	a_all_pins_analog: assert property (r.pin_cfg >= adcsc_pkg::PIN_CFG_ALL |->
		pin_analog_en == 4'hF)
		else $error("pins not all analog");

	// a launch may set the pin config in the same write, so busy is judged in the same cycle
	a_power_down: assert property (r.pin_cfg == 3'h0 |->
		pin_analog_en == 4'h0 && !core_power && !conv_busy)
		else $error("converter not powered down");

	a_one_channel: assert property ($onehot(core_channel_sel) && core_channel_sel[r.chan[1:0]])
		else $error("channel routing not one-hot");

	a_irq_raise: assert property (r.irq_flag && r.irq_en && r.master_en |-> conv_irq_req)
		else $error("interrupt not raised");

	// a converter clock tick that does not end the conversion
	sequence s_tick_mid;
		core_clk_tick && !done;
	endsequence

	sequence s_irq_clear;
		wr && paddr == adcsc_pkg::ADDR_IRQ_STATUS && pwdata[adcsc_pkg::IRQ_FLAG_BIT];
	endsequence

	// a relaunch zeroes the count and a divider change moves the limit the running count is compared with: both excuse a gap
	a_tick_div2: assert property (s_tick_mid ##0 r.div_sel == adcsc_pkg::DIV_SEL_2 |=>
		!core_clk_tick ##1 (core_clk_tick || !conv_busy || r.div_sel != adcsc_pkg::DIV_SEL_2))
		else $error("converter clock period not two cycles");

	a_tick_div8: assert property (s_tick_mid ##0 r.div_sel == adcsc_pkg::DIV_SEL_8 |=>
		(!core_clk_tick || r.count == 7'h00 || r.div_sel != adcsc_pkg::DIV_SEL_8) [*7] ##1
		(core_clk_tick || !conv_busy || r.count == 7'h00 || r.div_sel != adcsc_pkg::DIV_SEL_8))
		else $error("converter clock period not eight cycles");

	// the divider restarts at launch, so no short first period
	a_first_period: assert property (s_start_fall |=> !core_clk_tick)
		else $error("tick right after launch");

	a_launch_power: assert property (s_start_fall |=> core_power && !core_reset)
		else $error("core not running after launch");

	a_count_step: assert property (s_tick_mid |=>
		r.count == $past(r.count) + 7'h01 || !conv_busy)
		else $error("conversion count did not step on tick");

	a_irq_clear: assert property (s_irq_clear ##0 !done |=> !r.irq_flag)
		else $error("request flag not cleared by software");

	a_pins_partial: assert property (r.pin_cfg != 3'h0 && r.pin_cfg < adcsc_pkg::PIN_CFG_ALL |->
		pin_analog_en == (4'h1 << r.pin_cfg) - 4'h1)
		else $error("partial pin configuration wrong");

	a_held_reset: assert property (r.state == ST_HELD |-> core_reset && r.conversion_pending_flag)
		else $error("held state without core reset or end flag");

	a_result_high: assert property (rd_setup && hit && paddr == adcsc_pkg::ADDR_RESULT_HIGH |=>
		prdata[7:0] == $past(r.result[8:1]))
		else $error("high result byte wrong");

	a_result_low: assert property (rd_setup && paddr == adcsc_pkg::ADDR_RESULT_LOW |=>
		prdata[6:0] == 7'h00)
		else $error("unused low result bits not zero");

	a_result_byte: assert property (rd_setup && hit && paddr == adcsc_pkg::ADDR_RESULT_BYTE |=>
		prdata[7:0] == $past(r.result[7:0]))
		else $error("result byte wrong");

	// power down mid conversion keeps the old result and leaves the end flag high
	a_abort_keeps: assert property (conv_busy && !next_r.start && next_r.pin_cfg == 3'h0 |=>
		!conv_busy && r.conversion_pending_flag && $stable(r.result))
		else $error("power down during conversion not handled");
endmodule // adcsc_ctrl

// file: shared/adcsc_pkg.sv
// shared constants of the converter sequencer control block
package adcsc_pkg;
	// register byte offsets on the apb bus
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_RESULT_BYTE = 8'h04;
	localparam logic [7:0] ADDR_RESULT_LOW = 8'h08;
	localparam logic [7:0] ADDR_RESULT_HIGH = 8'h0C;
	localparam logic [7:0] ADDR_CLOCK_SRC = 8'h10;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
	// control register fields
	localparam int CTL_CHAN_LSB = 0;
	localparam int CTL_PIN_LSB = 3;
	localparam int CTL_EOC_BIT = 6;
	localparam int CTL_START_BIT = 7;
	// other register fields
	localparam int DIV_SEL_LSB = 0;
	localparam int IRQ_EN_BIT = 0;
	localparam int IRQ_MASTER_BIT = 1;
	localparam int IRQ_FLAG_BIT = 0;
	// reset values
	localparam logic [2:0] RST_CHAN = 3'h0;
	localparam logic [2:0] RST_PIN_CFG = 3'h0;
	localparam logic [1:0] RST_DIV_SEL = 2'h0;
	localparam logic RST_EOC = 1'b0;
	// converter clock divide selects and ratios
	localparam logic [1:0] DIV_SEL_2 = 2'h0;
	localparam logic [1:0] DIV_SEL_8 = 2'h1;
	localparam logic [1:0] DIV_SEL_32 = 2'h2;
	localparam int DIV_RATIO_2 = 2;
	localparam int DIV_RATIO_8 = 8;
	localparam int DIV_RATIO_32 = 32;
	// conversion length in converter clock periods
	localparam int CONV_PERIODS_8BIT = 64;
	localparam int CONV_PERIODS_9BIT = 76;
	// pin config at or above this puts all four pins to analog
	localparam logic [2:0] PIN_CFG_ALL = 3'h4;
endpackage

// file: verilog/adcsc_clkdiv.sv
// converter clock divider producing one tick per converter clock period
`timescale 1ns/100ps
module adcsc_clkdiv (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic clr,
	input wire logic [1:0] div_sel,
	// output
	output logic tick
);
	logic [4:0] cnt;
	logic [4:0] next_cnt;
	logic [4:0] lim;

	always_comb begin
		case (div_sel)
			adcsc_pkg::DIV_SEL_2: lim = 5'(adcsc_pkg::DIV_RATIO_2 - 1);
			adcsc_pkg::DIV_SEL_8: lim = 5'(adcsc_pkg::DIV_RATIO_8 - 1);
			// the undefined select runs at the slowest, safest rate
			default: lim = 5'(adcsc_pkg::DIV_RATIO_32 - 1);
		endcase
		tick = (cnt >= lim) && !clr;
		if (clr || tick) begin
			next_cnt = 5'h00;
		end else begin
			next_cnt = cnt + 5'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 5'h00;
		end else begin
			cnt <= next_cnt;
		end
	end
endmodule // adcsc_clkdiv

// file: verification/adcsc_core_model.sv
// behavioural model of the analog core behind the sequencer
`timescale 1ns/100ps
module adcsc_core_model #(
	parameter logic [35:0] VALS = 36'h0
) (
	// clock
	input wire logic pclk,
	// from sequencer
	input wire logic [3:0] core_channel_sel,
	input wire logic core_power,
	// to sequencer
	output logic [8:0] core_result
);
	logic flip = 1'b0;
	logic [8:0] pick;
	always @(posedge pclk) begin
		flip <= ~flip;
	end
	always_comb begin
		case (core_channel_sel)
			4'h1: pick = VALS[8:0];
			4'h2: pick = VALS[17:9];
			4'h4: pick = VALS[26:18];
			4'h8: pick = VALS[35:27];
			default: pick = 9'h155 ^ {9{flip}};
		endcase
	end
	// a powered down core holds no value, so show a moving pattern
	assign core_result = core_power ? pick : {9{flip}};
endmodule // adcsc_core_model

// file: verification/adc_sequencer_control_tb_top.sv
// self-checking bench for the converter sequencer control block
`timescale 1ns/100ps
module adc_sequencer_control_tb_top;
	localparam logic [35:0] VALS = {9'h05A, 9'h17E, 9'h0C3, 9'h1A5};
	localparam int N = adcsc_pkg::CONV_PERIODS_9BIT;
	localparam int N8 = adcsc_pkg::CONV_PERIODS_8BIT;
	localparam int DIVS[3] = '{adcsc_pkg::DIV_RATIO_2, adcsc_pkg::DIV_RATIO_8,
		adcsc_pkg::DIV_RATIO_32};
	localparam logic [7:0] CTL = adcsc_pkg::ADDR_CONTROL;
	localparam logic [7:0] RBY = adcsc_pkg::ADDR_RESULT_BYTE;
	localparam logic [7:0] RLO = adcsc_pkg::ADDR_RESULT_LOW;
	localparam logic [7:0] RHI = adcsc_pkg::ADDR_RESULT_HIGH;
	localparam logic [7:0] CKS = adcsc_pkg::ADDR_CLOCK_SRC;
	localparam logic [7:0] IEN = adcsc_pkg::ADDR_IRQ_ENABLE;
	localparam logic [7:0] IST = adcsc_pkg::ADDR_IRQ_STATUS;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic [31:0] prdata8, q8;
	logic pslverr8, e8, conv_busy8;
	int n8;
	int k;
	logic pready, pslverr, e, core_power, core_reset, core_clk_tick, conv_busy, conv_irq_req;
	logic [8:0] core_result;
	logic [3:0] core_channel_sel, pin_analog_en;
	int miscompares = 0;
	int tests_run = 0;
	int cyc = 0;
	int n;
	always #5 pclk = ~pclk;
	adcsc_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_result(core_result), .core_channel_sel(core_channel_sel),
		.core_power(core_power), .core_reset(core_reset), .core_clk_tick(core_clk_tick),
		.conv_busy(conv_busy), .pin_analog_en(pin_analog_en), .conv_irq_req(conv_irq_req));
	// 8-bit variant on the same bus and core: same writes, its own result map and length
	adcsc_ctrl #(.NINE_BIT(1'b0)) uut_byte (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata8),
		.pready(), .pslverr(pslverr8), .core_result(core_result), .core_channel_sel(),
		.core_power(), .core_reset(), .core_clk_tick(), .conv_busy(conv_busy8),
		.pin_analog_en(), .conv_irq_req());
	adcsc_core_model #(.VALS(VALS)) core (.pclk(pclk), .core_channel_sel(core_channel_sel),
		.core_power(core_power), .core_result(core_result));
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// request held until pready is seen at a rising edge
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		q8 = prdata8;
		e8 = pslverr8;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	// pin config 4 puts all pins analog; start set, then cleared to launch
	task automatic conv(input int sel, input int ch);
		logic [8:0] r;
		r = VALS[ch*9 +: 9];
		acc(1'b1, CKS, sel);
		acc(1'b1, CTL, 32'hA0 | ch);
		rd(CTL, 32'hE0 | ch);
		chk(core_reset, 1'b1);
		acc(1'b1, CTL, 32'h20 | ch);
		n = 0;
		n8 = 0;
		k = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
			k += core_clk_tick;
			if (conv_busy8 === 1'b1) begin
				n8 = n + 1;
			end
		end while (conv_busy === 1'b1 && n < 5000);
		chk(n, N * DIVS[sel]);
		chk(n8, N8 * DIVS[sel]);
		chk(k, N);
		rd(CTL, 32'h20 | ch);
		rd(RHI, r[8:1]);
		chk(e8, 1'b1);
		rd(RLO, {r[0], 7'h0});
		acc(1'b0, RBY, 32'h0);
		chk(q8, r[7:0]);
		chk(e, 1'b1);
		chk(conv_irq_req, 1'b1);
		rd(IST, 32'h1);
		acc(1'b1, IST, 32'h1);
		#1;
		chk(conv_irq_req, 1'b0);
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			summarize;
		end
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(CTL, 32'h0);
		chk(pin_analog_en, 4'h0);
		chk(core_power, 1'b0);
		rd(RBY, 32'h0);
		chk(e, 1'b1);
		chk(e8, 1'b0);
		chk(q8, 32'h0);
		$display("test reset done");
		for (int c = 0; c < 8; c++) begin
			acc(1'b1, CTL, c << 3);
			#1;
			chk(pin_analog_en, c >= 4 ? 4'hF : 4'((1 << c) - 1));
			chk(core_power, c != 0);
		end
		for (int c = 0; c < 4; c++) begin
			acc(1'b1, CTL, 32'h20 | c);
			#1;
			chk(core_channel_sel, 4'h1 << c);
		end
		$display("test pins and channels done");
		acc(1'b1, IEN, 32'h3);
		rd(IEN, 32'h3);
		for (int s = 0; s < 3; s++) begin
			conv(s, s);
		end
		conv(0, 3);
		$display("test conversions done");
		acc(1'b1, CTL, 32'hA1);
		acc(1'b1, CTL, 32'h21);
		repeat (20) @(posedge pclk);
		rd(RHI, VALS[35:28]);
		acc(1'b1, CTL, 32'hA1);
		#1;
		chk(conv_busy, 1'b0);
		rd(CTL, 32'hE1);
		rd(RHI, VALS[35:28]);
		acc(1'b1, CTL, 32'h21);
		acc(1'b1, CTL, 32'h01);
		#1;
		chk(conv_busy, 1'b0);
		chk(conv_busy8, 1'b0);
		rd(CTL, 32'h41);
		rd(RHI, VALS[35:28]);
		$display("test abort done");
		summarize;
	end
endmodule // adc_sequencer_control_tb_top
